// *** include/cmrd_defs.svh ***
// Opcode patterns, field positions and reset values for the move/return decoder
`ifndef CMRD_DEFS_SVH
`define CMRD_DEFS_SVH
`define CMRD_STORE_MASK 14'h3F80
`define CMRD_STORE_PAT 14'h0080
`define CMRD_IDLE_MASK 14'h3F9F
`define CMRD_IDLE_PAT 14'h0000
`define CMRD_IRET_WORD 14'h0009
`define CMRD_OPTLD_WORD 14'h0062
`define CMRD_RETLIT_MASK 14'h3C00
`define CMRD_RETLIT_PAT 14'h3400
`define CMRD_ADDR_MSB 6
`define CMRD_LIT_MSB 7
`define CMRD_GIE_BIT 7
`define CMRD_PC_RESET 13'h0000
`define CMRD_BYTE_RESET 8'h00
`define CMRD_OPT_RESET 8'hFF
`define CMRD_ADDR_RESET 7'h00
`define CMRD_PC_STEP 13'h0001
`define CMRD_RETLIT_OPC 4'hD
`endif

// *** include/cmrd_pkg.sv ***
// Types for the move/return decoder
`default_nettype none
package cmrd_pkg;
    typedef enum logic [2:0] {
        CMRD_OP_NONE,
        CMRD_OP_STORE,
        CMRD_OP_IDLE,
        CMRD_OP_IRET,
        CMRD_OP_OPTLD,
        CMRD_OP_RETLIT
    } cmrd_op_type;
    typedef enum logic {
        CMRD_EXEC,
        CMRD_FLUSH
    } cmrd_state_type;
endpackage
`default_nettype wire

// *** rtl/cmrd_core.sv ***
// Decode and execute of store, idle, interrupt return, option load, literal return
// Behaviour
// - Store accumulator to addressed file register
// - Interrupt return pops stack into PC, two cycles
// - Interrupt return sets global interrupt enable
// - Option load copies accumulator; also file-mapped
// - Literal return loads immediate, ignores don't-care bits
// - Literal return pops stack into PC
// - Literal return two cycles, flush, no flags
`timescale 1ns/10ps
`default_nettype none
`include "cmrd_defs.svh"
module cmrd_core
    import cmrd_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [13:0] instr,
    input wire logic [7:0] accum_in,
    input wire logic [12:0] stack_top,
    input wire logic [7:0] interrupt_control_reg_in,
    input wire logic opt_file_we,
    input wire logic [7:0] opt_file_wdata,
    output logic [12:0] pc,
    output logic stack_pop,
    output logic file_we,
    output logic [6:0] file_addr,
    output logic [7:0] file_wdata,
    output logic accum_we,
    output logic [7:0] accum_wdata,
    output logic interrupt_control_reg_we,
    output logic [7:0] interrupt_control_reg_wdata,
    output logic [7:0] option_reg,
    output logic flush,
    output logic flags_we
);
    function automatic logic match(input logic [13:0] w, input logic [13:0] m,
                                   input logic [13:0] p);
        match = (w & m) == p;
    endfunction

    logic [12:0] pc_q, pc_d;
    logic pop_q, fwe_q, awe_q, iwe_q, flush_q, flags_q;
    logic [6:0] faddr_q;
    logic [7:0] fdata_q, adata_q, idata_q, opt_q;
    cmrd_state_type state_q, state_d;
    cmrd_op_type op;

    wire logic executing = (state_q == CMRD_EXEC);
    wire logic is_store = match(instr, `CMRD_STORE_MASK, `CMRD_STORE_PAT);
    wire logic is_idle = match(instr, `CMRD_IDLE_MASK, `CMRD_IDLE_PAT);
    wire logic is_iret = (instr == `CMRD_IRET_WORD);
    wire logic is_optld = (instr == `CMRD_OPTLD_WORD);
    wire logic is_retlit = match(instr, `CMRD_RETLIT_MASK, `CMRD_RETLIT_PAT);
    wire logic is_return = executing && (is_iret || is_retlit);
    wire logic do_store = (op == CMRD_OP_STORE);
    wire logic do_iret = (op == CMRD_OP_IRET);
    wire logic do_optld = (op == CMRD_OP_OPTLD);
    wire logic do_retlit = (op == CMRD_OP_RETLIT);
    wire logic opt_load = do_optld || opt_file_we;
    wire logic [7:0] opt_d = do_optld ? accum_in : opt_file_wdata;
    wire logic [7:0] gie_mask = 8'h01 << `CMRD_GIE_BIT;

    always_comb begin
        if (!executing) op = CMRD_OP_NONE;
        else if (is_store) op = CMRD_OP_STORE;
        else if (is_iret) op = CMRD_OP_IRET;
        else if (is_optld) op = CMRD_OP_OPTLD;
        else if (is_retlit) op = CMRD_OP_RETLIT;
        else if (is_idle) op = CMRD_OP_IDLE;
        else op = CMRD_OP_NONE;
    end

    // Returns take the stack top; flushed slot and others just advance
    assign pc_d = is_return ? stack_top : 13'(pc_q + `CMRD_PC_STEP);
    assign state_d = is_return ? CMRD_FLUSH : CMRD_EXEC;

    // Program counter and flush slot
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc_q <= `CMRD_PC_RESET;
            state_q <= CMRD_EXEC;
        end else begin
            pc_q <= pc_d;
            state_q <= state_d;
        end
    end

    // Stack pop and flush pulses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pop_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            pop_q <= is_return;
            flush_q <= is_return;
        end
    end

    // File register write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fwe_q <= 1'b0;
            faddr_q <= `CMRD_ADDR_RESET;
            fdata_q <= `CMRD_BYTE_RESET;
        end else begin
            fwe_q <= do_store;
            faddr_q <= instr[`CMRD_ADDR_MSB:0];
            fdata_q <= accum_in;
        end
    end

    // Accumulator write with literal
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awe_q <= 1'b0;
            adata_q <= `CMRD_BYTE_RESET;
        end else begin
            awe_q <= do_retlit;
            adata_q <= instr[`CMRD_LIT_MSB:0];
        end
    end

    // Interrupt-control write with enable forced on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            iwe_q <= 1'b0;
            idata_q <= `CMRD_BYTE_RESET;
        end else begin
            iwe_q <= do_iret;
            idata_q <= interrupt_control_reg_in | gie_mask;
        end
    end

    // Option register, instruction load beats file write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            opt_q <= `CMRD_OPT_RESET;
        end else if (opt_load) begin
            opt_q <= opt_d;
        end
    end

    // No instruction here writes status flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_q <= 1'b0;
        end else begin
            flags_q <= 1'b0;
        end
    end

    assign pc = pc_q;
    assign stack_pop = pop_q;
    assign file_we = fwe_q;
    assign file_addr = faddr_q;
    assign file_wdata = fdata_q;
    assign accum_we = awe_q;
    assign accum_wdata = adata_q;
    assign interrupt_control_reg_we = iwe_q;
    assign interrupt_control_reg_wdata = idata_q;
    assign option_reg = opt_q;
    assign flush = flush_q;
    assign flags_we = flags_q;

    a_store_write: assert property (@(posedge mclk) disable iff (rst)
        executing && is_store |=> file_we && file_wdata == $past(accum_in))
        else $error("store did not write file register");
    a_store_addr: assert property (@(posedge mclk) disable iff (rst)
        executing && is_store |=> file_addr == $past(instr[`CMRD_ADDR_MSB:0]))
        else $error("store address wrong");
    a_iret_pc: assert property (@(posedge mclk) disable iff (rst)
        executing && is_iret |=> stack_pop && pc == $past(stack_top) ##1 !stack_pop)
        else $error("interrupt return pc or pop wrong");
    a_iret_gie: assert property (@(posedge mclk) disable iff (rst)
        executing && is_iret |=> interrupt_control_reg_we && interrupt_control_reg_wdata[`CMRD_GIE_BIT])
        else $error("global interrupt enable not set");
    a_iret_keep: assert property (@(posedge mclk) disable iff (rst)
        executing && is_iret |=> interrupt_control_reg_wdata[6:0] == $past(interrupt_control_reg_in[6:0]))
        else $error("interrupt control low bits changed");
    a_optld_copy: assert property (@(posedge mclk) disable iff (rst)
        executing && is_optld |=> option_reg == $past(accum_in))
        else $error("option load missed");
    a_option_file: assert property (@(posedge mclk) disable iff (rst)
        !(executing && is_optld) && opt_file_we |=> option_reg == $past(opt_file_wdata))
        else $error("option file write missed");
    a_option_hold: assert property (@(posedge mclk) disable iff (rst)
        !(executing && is_optld) && !opt_file_we |=> $stable(option_reg))
        else $error("option register changed");
    a_retlit_acc: assert property (@(posedge mclk) disable iff (rst)
        executing && is_retlit |=> accum_we && accum_wdata == $past(instr[`CMRD_LIT_MSB:0]))
        else $error("literal not loaded");
    a_retlit_any: assert property (@(posedge mclk) disable iff (rst)
        executing && instr[13:10] == `CMRD_RETLIT_OPC |=> accum_we && stack_pop && flush)
        else $error("literal return variant not decoded");
    a_retlit_pc: assert property (@(posedge mclk) disable iff (rst)
        executing && is_retlit |=> pc == $past(stack_top))
        else $error("literal return pc wrong");
    a_flush_slot: assert property (@(posedge mclk) disable iff (rst)
        is_return |=> flush && !executing ##1 executing && !flush)
        else $error("return flush slot wrong");
    a_flush_quiet: assert property (@(posedge mclk) disable iff (rst)
        !executing |=> !file_we && !accum_we && !interrupt_control_reg_we && !stack_pop)
        else $error("flushed instruction executed");
    a_idle_quiet: assert property (@(posedge mclk) disable iff (rst)
        op == CMRD_OP_IDLE |=> !file_we && !accum_we && !interrupt_control_reg_we && !stack_pop
            && pc == $past(pc) + 13'h0001)
        else $error("idle changed state");
    a_no_flags: assert property (@(posedge mclk) disable iff (rst) !flags_we)
        else $error("flags written");

    c_store: cover property (@(posedge mclk) disable iff (rst) op == CMRD_OP_STORE);
    c_iret: cover property (@(posedge mclk) disable iff (rst) op == CMRD_OP_IRET);
    c_retlit: cover property (@(posedge mclk) disable iff (rst) op == CMRD_OP_RETLIT);
    c_optld: cover property (@(posedge mclk) disable iff (rst) op == CMRD_OP_OPTLD);
    c_idle: cover property (@(posedge mclk) disable iff (rst) op == CMRD_OP_IDLE);
endmodule
`default_nettype wire

// *** verification/cmrd_core_tb.sv ***
// Self-checking bench for the move/return decoder
`timescale 1ns/10ps
`default_nettype none
module cmrd_core_tb;
    import cmrd_pkg::*;
    logic mclk = 0, rst = 1, ofwe = 0, pop, fwe, awe, iwe, fl, fgwe, e_fl = 0;
    logic [13:0] instr = 0;
    logic [7:0] acc = 0, icn = 0, ofwd = 0, fwd, awd, iwd, opt, e_opt = 8'hFF;
    logic [12:0] st = 0, pc, e_pc = 0;
    logic [6:0] fad;
    logic [31:0] seed = 32'hDE3D6AB5;
    int bad_count = 0, total_checks = 0;
    always #4 mclk = ~mclk;
    cmrd_core DUT (.mclk(mclk), .rst(rst), .instr(instr), .accum_in(acc), .stack_top(st),
        .interrupt_control_reg_in(icn), .opt_file_we(ofwe), .opt_file_wdata(ofwd), .pc(pc), .stack_pop(pop),
        .file_we(fwe), .file_addr(fad), .file_wdata(fwd), .accum_we(awe), .accum_wdata(awd),
        .interrupt_control_reg_we(iwe), .interrupt_control_reg_wdata(iwd), .option_reg(opt), .flush(fl), .flags_we(fgwe));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One instruction slot, then outputs compared against the bench model
    task automatic step(input logic [13:0] w, input logic fwr);
        logic ex, so, rl, ir;
        seed = lfsr(seed);
        instr = w;
        acc = seed[7:0];
        st = seed[20:8];
        icn = seed[31:24];
        ofwd = seed[15:8];
        ofwe = fwr & ~e_fl;
        ex = ~e_fl;
        so = ex && w[13:7] == 7'h01;
        rl = ex && w[13:10] == 4'hD;
        ir = ex && w == 14'h0009;
        @(posedge mclk);
        #1;
        chk(fwe, so);
        if (so) chk({fad, fwd}, {w[6:0], acc});
        chk(awe, rl);
        if (rl) chk(awd, w[7:0]);
        chk({pop, fl}, {rl | ir, rl | ir});
        chk(iwe, ir);
        if (ir) chk(iwd, icn | 8'h80);
        if (ex && w == 14'h0062) begin
            e_opt = acc;
        end else if (ofwe) begin
            e_opt = ofwd;
        end
        chk(opt, e_opt);
        e_pc = (rl | ir) ? st : e_pc + 13'h0001;
        chk(pc, e_pc);
        chk(fgwe, 1'b0);
        e_fl = rl | ir;
    endtask
    initial begin
        logic [13:0] w;
        repeat (8) @(posedge mclk);
        #1;
        rst = 0;
        chk(opt, 8'hFF);
        step(14'h37FF, 0);
        step(14'h3455, 1);
        step(14'h0009, 0);
        step(14'h0009, 0);
        step(14'h0062, 1);
        step(14'h00FF, 1);
        step(14'h0060, 0);
        step(14'h0008, 0);
        for (int i = 0; i < 400; i++) begin
            seed = lfsr(seed);
            case (seed[2:0])
                0: w = {7'h01, seed[9:3]};
                1: w = {7'h00, seed[4:3], 5'h00};
                2: w = 14'h0009;
                3: w = 14'h0062;
                4: w = {4'hD, seed[12:3]};
                default: w = seed[16:3];
            endcase
            step(w, seed[20]);
        end
        summarize();
    end
    initial begin
        #20000;
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
